// >>> include/brd_pkg.sv
// shared constants and types of the bus refresh / dma sequencer
// assumes a 250 MHz core clock; all times below are in ns
package brd_pkg;

  localparam int CLK_NS              = 4;
  localparam int REFRESH_INTERVAL_NS = 15000;
  localparam int BUS_CLK_NS          = 125;
  localparam int REF_ADDR_SETUP_NS   = 125;
  localparam int REF_CMD_NS          = 250;
  localparam int REF_HANDBACK_NS     = 250;
  localparam int DMA_ACK_SETUP_NS    = 145;
  localparam int DMA_RD_TO_WR_NS     = 235;
  localparam int DMA_WR_NS           = 639;
  localparam int DMA_RD_HOLD_NS      = 50;
  localparam int DMA_ACK_HOLD_NS     = 60;

  // least times round up, never below one cycle
  function automatic int cyc_up(input int ns);
    int c;
    c = (ns + CLK_NS - 1) / CLK_NS;
    return (c < 1) ? 1 : c;
  endfunction : cyc_up

  localparam int REFRESH_INTERVAL_CYC = cyc_up(REFRESH_INTERVAL_NS);
  localparam int BUS_CLK_CYC          = cyc_up(BUS_CLK_NS);
  localparam int CNT_W                = 8;
  localparam int TMR_W                = 12;

  localparam logic [CNT_W-1:0] REF_ADDR_SETUP_CYC =
    CNT_W'(cyc_up(REF_ADDR_SETUP_NS));
  localparam logic [CNT_W-1:0] REF_CMD_CYC      = CNT_W'(cyc_up(REF_CMD_NS));
  localparam logic [CNT_W-1:0] REF_HANDBACK_CYC =
    CNT_W'(cyc_up(REF_HANDBACK_NS));
  localparam logic [CNT_W-1:0] DMA_ACK_SETUP_CYC =
    CNT_W'(cyc_up(DMA_ACK_SETUP_NS));
  localparam logic [CNT_W-1:0] DMA_RD_TO_WR_CYC =
    CNT_W'(cyc_up(DMA_RD_TO_WR_NS));
  localparam logic [CNT_W-1:0] DMA_WR_CYC     = CNT_W'(cyc_up(DMA_WR_NS));
  localparam logic [CNT_W-1:0] DMA_RD_HOLD_CYC = CNT_W'(cyc_up(DMA_RD_HOLD_NS));
  localparam logic [CNT_W-1:0] DMA_ACK_HOLD_CYC =
    CNT_W'(cyc_up(DMA_ACK_HOLD_NS));
  localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;

  localparam int ADDR_W      = 24;
  localparam int SYS_ADDR_W  = 20;
  localparam int UPPER_LSB   = 17;
  localparam int UPPER_W     = 7;
  localparam int ROW_W       = 8;
  localparam int LOW_MB_BITS = 4;
  localparam int NUM_CH      = 8;
  localparam int CH_W        = 3;
  localparam int LAST_NARROW_CH = 3;
  localparam logic [CH_W-1:0] CH_NONE = 3'h4;
  localparam logic [ADDR_W-1:0] STEP_NARROW = 24'h00_0001;
  localparam logic [ADDR_W-1:0] STEP_WIDE   = 24'h00_0002;

  typedef enum logic [1:0] {OWN_CPU, OWN_REFRESH, OWN_DMA, OWN_CARD}
    brd_owner_type;

  typedef enum {
    ST_CPU, ST_REF_ADDR, ST_REF_CMD, ST_REF_RDY, ST_REF_END,
    ST_DMA_ACK, ST_DMA_RD, ST_DMA_WR, ST_DMA_RDY, ST_DMA_HOLD,
    ST_DMA_END, ST_CARD
  } brd_state_type;

endpackage : brd_pkg

// >>> include/brd_tmr_if.sv
// refresh interval timer link between sequencer and timer
// both ends on mclk
`timescale 1ns/1ps
interface brd_tmr_if;
  logic due;
  logic restart;
  modport timer (output due, input restart);
  modport user  (input due, output restart);
endinterface : brd_tmr_if

// >>> core/brd_sync.sv
// two-flop synchroniser for a vector of pin levels
// inputs are asynchronous to mclk; each bit is a level
`timescale 1ns/1ps
module brd_sync
  import brd_pkg::*;
#(
  parameter int W = 1
)(
  input  wire logic         mclk,
  input  wire logic         rst,
  input  wire logic [W-1:0] din,
  input  wire logic [W-1:0] rstVal,
  output logic      [W-1:0] dout
);
  logic [W-1:0] meta_r;
  logic [W-1:0] meta_nxt;
  logic [W-1:0] dout_nxt;

  always_comb
  begin
    meta_nxt = din;
    dout_nxt = meta_r;
  end

  // reset value is fixed at zero here; the rstVal port is not used
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      meta_r <= '0;
      dout   <= '0;
    end
    else
    begin
      meta_r <= meta_nxt;
      dout   <= dout_nxt;
    end
  end

  logic unusedRstVal;
  assign unusedRstVal = ^rstVal;
endmodule : brd_sync

// >>> core/brd_refresh_timer.sv
// refresh interval timer: raises due once the interval has run out
// restart is a one-cycle pulse from the sequencer at each refresh
`timescale 1ns/1ps
module brd_refresh_timer
  import brd_pkg::*;
(
  input  wire logic mclk,
  input  wire logic rst,
  brd_tmr_if.timer  tmr
);
  logic [TMR_W-1:0] cnt_r;
  logic [TMR_W-1:0] cnt_nxt;
  logic             due_r;
  logic             due_nxt;

  localparam logic [TMR_W-1:0] LAST = TMR_W'(REFRESH_INTERVAL_CYC - 1);

  always_comb
  begin
    cnt_nxt = cnt_r;
    due_nxt = due_r;
    if (tmr.restart)
    begin
      cnt_nxt = '0;
      due_nxt = 1'b0;
    end
    else if (cnt_r == LAST)
      due_nxt = 1'b1;
    else
      cnt_nxt = cnt_r + 1'b1;
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      cnt_r <= '0;
      due_r <= 1'b0;
    end
    else
    begin
      cnt_r <= cnt_nxt;
      due_r <= due_nxt;
    end
  end

  assign tmr.due = due_r;
endmodule : brd_refresh_timer

// >>> core/brd_bus_sequencer.sv
// bus sequencer: refresh, fly-by dma transfer and ownership hand-over
// bus pins asynchronous to mclk; two-way pins split into out and enable only, with no input side
`timescale 1ns/1ps
module brd_bus_sequencer
  import brd_pkg::*;
(
  input  wire logic                  mclk,
  input  wire logic                  rst,
  input  wire logic [NUM_CH-1:0]     dmaRequestLine,
  input  wire logic                  refreshRequestN,
  input  wire logic                  channelReady,
  input  wire logic                  secondaryOwnerN,
  input  wire logic                  memWideSelectN,
  input  wire logic                  ioWideSelectN,
  input  wire logic                  zeroWaitRequestN,
  input  wire logic [NUM_CH-1:0]     cascadeMode,
  input  wire logic                  memToIo,
  input  wire logic [ADDR_W-1:0]     memBase,
  input  wire logic [15:0]           xferCount,
  output logic                       memReadCmdN,
  output logic                       memWriteCmdN,
  output logic                       ioReadCmdN,
  output logic                       ioWriteCmdN,
  output logic                       lowMbReadStrobeN,
  output logic                       lowMbWriteStrobeN,
  output logic                       cmdOe,
  output logic [SYS_ADDR_W-1:0]      systemAddress,
  output logic [UPPER_W-1:0]         upperLatchableAddress,
  output logic                       addrOe,
  output logic [NUM_CH-1:0]          dmaAcknowledgeN,
  output logic                       dmaAddressEnable,
  output logic                       terminalCount,
  output logic                       dataSwapEnable,
  output brd_owner_type              busOwner
);
  localparam int SW = NUM_CH + 4;

  // lowest numbered pending channel wins; channel 4 is never a bus channel
  function automatic logic [CH_W-1:0] pick_ch(input logic [NUM_CH-1:0] r);
    logic [CH_W-1:0] c;
    c = CH_NONE;
    for (int i = NUM_CH - 1; i >= 0; i--)
      if (r[i] && i != int'(CH_NONE))
        c = CH_W'(i);
    return c;
  endfunction : pick_ch

  function automatic logic low_mb(input logic [ADDR_W-1:0] a);
    return a[ADDR_W-1 -: LOW_MB_BITS] == '0;
  endfunction : low_mb

  logic [SW-1:0] syncIn;
  logic [SW-1:0] syncOut;
  logic [NUM_CH-1:0] drqS;
  logic refReqNS;
  logic readyS;
  logic secOwnNS;
  logic memWideNS;

  // zero-wait and i/o wide select are deliberately never looked at
  assign syncIn = {memWideSelectN, secondaryOwnerN, channelReady,
                   refreshRequestN, dmaRequestLine};

  brd_sync #(.W(SW)) u_sync (
    .mclk   (mclk),
    .rst    (rst),
    .din    (syncIn),
    .rstVal ({SW{1'b0}}),
    .dout   (syncOut)
  );

  assign drqS      = syncOut[NUM_CH-1:0];
  assign refReqNS  = syncOut[NUM_CH];
  assign readyS    = syncOut[NUM_CH+1];
  assign secOwnNS  = syncOut[NUM_CH+2];
  assign memWideNS = syncOut[NUM_CH+3];

  brd_tmr_if tmrBus ();

  brd_refresh_timer u_timer (
    .mclk (mclk),
    .rst  (rst),
    .tmr  (tmrBus.timer)
  );

  // bus clock rate as a one-cycle tick, plus every second tick for dma
  logic [CNT_W-1:0] div_r, div_nxt;
  logic pair_r, pair_nxt;
  logic busTick;
  assign busTick = (div_r == '0);

  always_comb
  begin
    div_nxt  = busTick ? CNT_W'(BUS_CLK_CYC - 1) : div_r - CNT_ONE;
    pair_nxt = busTick ? ~pair_r : pair_r;
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      div_r  <= '0;
      pair_r <= 1'b0;
    end
    else
    begin
      div_r  <= div_nxt;
      pair_r <= pair_nxt;
    end
  end

  brd_state_type st_r, st_nxt;
  logic [CNT_W-1:0] cnt_r, cnt_nxt;
  logic [CH_W-1:0] ch_r, ch_nxt;
  logic [ROW_W-1:0] row_r, row_nxt;
  logic [ADDR_W-1:0] addr_r, addr_nxt;
  logic [15:0] left_r, left_nxt;
  logic armed_r, armed_nxt;
  logic fromCard_r, fromCard_nxt;
  logic restart_r, restart_nxt;
  logic mrd_nxt, mwr_nxt, ird_nxt, iwr_nxt, lmr_nxt, lmw_nxt;
  logic cmdOe_nxt, addrOe_nxt, aen_nxt, tc_nxt, swap_nxt;
  logic [SYS_ADDR_W-1:0] sa_nxt;
  logic [UPPER_W-1:0] la_nxt;
  logic [NUM_CH-1:0] dma_acknowledge_n_nxt;
  brd_owner_type own_nxt;
  logic [CH_W-1:0] reqCh;
  logic cntDone, wide, rdOn;

  assign reqCh   = pick_ch(drqS);
  assign cntDone = (cnt_r == CNT_ONE);
  assign wide    = ch_r > CH_W'(LAST_NARROW_CH);
  assign tmrBus.restart = restart_r;

  always_comb
  begin
    st_nxt = st_r;
    cnt_nxt = cntDone ? cnt_r : cnt_r - CNT_ONE;
    ch_nxt = ch_r;
    row_nxt = row_r;
    addr_nxt = addr_r;
    left_nxt = left_r;
    armed_nxt = armed_r;
    fromCard_nxt = fromCard_r;
    restart_nxt = 1'b0;
    rdOn = 1'b0;
    case (st_r)
      ST_CPU:
        if (tmrBus.due)
        begin
          st_nxt = ST_REF_ADDR;
          cnt_nxt = REF_ADDR_SETUP_CYC;
          fromCard_nxt = 1'b0;
        end
        else if (reqCh != CH_NONE)
        begin
          ch_nxt = reqCh;
          cnt_nxt = DMA_ACK_SETUP_CYC;
          st_nxt = cascadeMode[reqCh] ? ST_CARD : ST_DMA_ACK;
          // a cascade grant moves no data, so it must not load a block
          if (!armed_r && !cascadeMode[reqCh])
          begin
            addr_nxt = memBase;
            left_nxt = xferCount;
            armed_nxt = 1'b1;
          end
        end
      ST_REF_ADDR:
        if (cntDone)
        begin
          st_nxt = ST_REF_CMD;
          cnt_nxt = REF_CMD_CYC;
          restart_nxt = 1'b1;
        end
      ST_REF_CMD:
      begin
        rdOn = 1'b1;
        if (cntDone)
          st_nxt = readyS ? ST_REF_END : ST_REF_RDY;
      end
      ST_REF_RDY:
      begin
        rdOn = 1'b1;
        if (busTick && readyS)
          st_nxt = ST_REF_END;
      end
      ST_REF_END:
      begin
        if (st_r != st_nxt || cnt_r == '0)
          cnt_nxt = REF_HANDBACK_CYC;
        row_nxt = row_r;
        if (cntDone)
        begin
          row_nxt = row_r + 1'b1;
          st_nxt = fromCard_r ? ST_CARD : ST_CPU;
        end
      end
      ST_DMA_ACK:
        if (cntDone)
        begin
          st_nxt = ST_DMA_RD;
          cnt_nxt = DMA_RD_TO_WR_CYC;
        end
      ST_DMA_RD:
      begin
        rdOn = 1'b1;
        if (cntDone)
        begin
          st_nxt = ST_DMA_WR;
          cnt_nxt = DMA_WR_CYC;
        end
      end
      ST_DMA_WR:
      begin
        rdOn = 1'b1;
        if (cntDone)
        begin
          st_nxt = readyS ? ST_DMA_HOLD : ST_DMA_RDY;
          cnt_nxt = DMA_RD_HOLD_CYC;
        end
      end
      ST_DMA_RDY:
      begin
        rdOn = 1'b1;
        // reload: the counter has run down during the ready stretch
        if (busTick && pair_r && readyS)
        begin
          st_nxt = ST_DMA_HOLD;
          cnt_nxt = DMA_RD_HOLD_CYC;
        end
      end
      ST_DMA_HOLD:
      begin
        rdOn = 1'b1;
        if (cntDone)
        begin
          st_nxt = ST_DMA_END;
          cnt_nxt = DMA_ACK_HOLD_CYC;
        end
      end
      ST_DMA_END:
        if (cntDone)
        begin
          // one transfer per grant so a due refresh gets in between
          st_nxt = ST_CPU;
          if (left_r == '0)
            armed_nxt = 1'b0;
          else
          begin
            left_nxt = left_r - 1'b1;
            addr_nxt = addr_r + (wide ? STEP_WIDE : STEP_NARROW);
          end
        end
      ST_CARD:
        if (!refReqNS)
        begin
          st_nxt = ST_REF_ADDR;
          cnt_nxt = REF_ADDR_SETUP_CYC;
          fromCard_nxt = 1'b1;
        end
        else if (!drqS[ch_r])
          st_nxt = ST_CPU;
      default:
        st_nxt = ST_CPU;
    endcase
    if (st_nxt == ST_REF_END && st_r != ST_REF_END)
      cnt_nxt = REF_HANDBACK_CYC;
  end

  // next values of the pin outputs, derived from the next state
  always_comb
  begin
    mrd_nxt = 1'b1;
    mwr_nxt = 1'b1;
    ird_nxt = 1'b1;
    iwr_nxt = 1'b1;
    cmdOe_nxt = 1'b0;
    addrOe_nxt = 1'b0;
    aen_nxt = 1'b0;
    tc_nxt = 1'b0;
    swap_nxt = 1'b0;
    sa_nxt = '0;
    la_nxt = '0;
    dma_acknowledge_n_nxt = '1;
    own_nxt = OWN_CPU;
    case (st_nxt)
      ST_REF_ADDR, ST_REF_CMD, ST_REF_RDY, ST_REF_END:
      begin
        own_nxt = OWN_REFRESH;
        cmdOe_nxt = (st_nxt != ST_REF_END);
        addrOe_nxt = cmdOe_nxt;
        sa_nxt[ROW_W-1:0] = row_nxt;
        mrd_nxt = !(rdOn && st_nxt == st_r) && st_nxt != ST_REF_CMD;
        mrd_nxt = mrd_nxt && st_nxt != ST_REF_RDY;
        // data lines never driven here and never sampled
      end
      ST_DMA_ACK, ST_DMA_RD, ST_DMA_WR, ST_DMA_RDY, ST_DMA_HOLD,
      ST_DMA_END:
      begin
        own_nxt = OWN_DMA;
        cmdOe_nxt = 1'b1;
        addrOe_nxt = 1'b1;
        aen_nxt = 1'b1;
        dma_acknowledge_n_nxt[ch_nxt] = 1'b0;
        sa_nxt = addr_nxt[SYS_ADDR_W-1:0];
        la_nxt = addr_nxt[UPPER_LSB +: UPPER_W];
        tc_nxt = (left_nxt == '0);
        swap_nxt = !(ch_nxt > CH_W'(LAST_NARROW_CH)) && !memWideNS;
        if (st_nxt inside {ST_DMA_RD, ST_DMA_WR, ST_DMA_RDY, ST_DMA_HOLD})
        begin
          mrd_nxt = !memToIo;
          ird_nxt = memToIo;
          mrd_nxt = memToIo ? 1'b0 : 1'b1;
          ird_nxt = memToIo ? 1'b1 : 1'b0;
        end
        if (st_nxt inside {ST_DMA_WR, ST_DMA_RDY})
        begin
          iwr_nxt = !memToIo;
          mwr_nxt = memToIo;
        end
      end
      ST_CARD:
      begin
        own_nxt = OWN_CARD;
        dma_acknowledge_n_nxt[ch_nxt] = 1'b0;
      end
      default:
        own_nxt = OWN_CPU;
    endcase
    lmr_nxt = mrd_nxt || !low_mb(own_nxt == OWN_DMA ? addr_nxt : '0);
    lmw_nxt = mwr_nxt || !low_mb(own_nxt == OWN_DMA ? addr_nxt : '0);
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      st_r <= ST_CPU;
      cnt_r <= '0;
      ch_r <= CH_NONE;
      row_r <= '0;
      addr_r <= '0;
      left_r <= '0;
      armed_r <= 1'b0;
      fromCard_r <= 1'b0;
      restart_r <= 1'b0;
      memReadCmdN <= 1'b1;
      memWriteCmdN <= 1'b1;
      ioReadCmdN <= 1'b1;
      ioWriteCmdN <= 1'b1;
      lowMbReadStrobeN <= 1'b1;
      lowMbWriteStrobeN <= 1'b1;
      cmdOe <= 1'b0;
      addrOe <= 1'b0;
      systemAddress <= '0;
      upperLatchableAddress <= '0;
      dmaAcknowledgeN <= '1;
      dmaAddressEnable <= 1'b0;
      terminalCount <= 1'b0;
      dataSwapEnable <= 1'b0;
      busOwner <= OWN_CPU;
    end
    else
    begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      ch_r <= ch_nxt;
      row_r <= row_nxt;
      addr_r <= addr_nxt;
      left_r <= left_nxt;
      armed_r <= armed_nxt;
      fromCard_r <= fromCard_nxt;
      restart_r <= restart_nxt;
      memReadCmdN <= mrd_nxt;
      memWriteCmdN <= mwr_nxt;
      ioReadCmdN <= ird_nxt;
      ioWriteCmdN <= iwr_nxt;
      lowMbReadStrobeN <= lmr_nxt;
      lowMbWriteStrobeN <= lmw_nxt;
      cmdOe <= cmdOe_nxt;
      addrOe <= addrOe_nxt;
      systemAddress <= sa_nxt;
      upperLatchableAddress <= la_nxt;
      dmaAcknowledgeN <= dma_acknowledge_n_nxt;
      dmaAddressEnable <= aen_nxt;
      terminalCount <= tc_nxt;
      dataSwapEnable <= swap_nxt;
      busOwner <= own_nxt;
    end
  end

  // card status and the ignored selects are observed only, never acted on
  logic unusedPins;
  assign unusedPins = secOwnNS ^ ioWideSelectN ^ zeroWaitRequestN;
endmodule : brd_bus_sequencer

// >>> bench/brd_seq_properties.sv
// pin-level assertions for the bus sequencer
// bound to brd_bus_sequencer; one mclk domain, rst async high
`timescale 1ns/1ps
module brd_seq_chk
  import brd_pkg::*;
(
  input wire logic                  mclk,
  input wire logic                  rst,
  input wire logic                  channelReady,
  input wire logic                  memReadCmdN,
  input wire logic                  memWriteCmdN,
  input wire logic                  ioReadCmdN,
  input wire logic                  ioWriteCmdN,
  input wire logic                  lowMbReadStrobeN,
  input wire logic                  cmdOe,
  input wire logic                  addrOe,
  input wire logic [SYS_ADDR_W-1:0] systemAddress,
  input wire logic [UPPER_W-1:0]    upperLatchableAddress,
  input wire logic [NUM_CH-1:0]     dmaAcknowledgeN,
  input wire logic                  dmaAddressEnable,
  input wire logic                  terminalCount,
  input wire logic                  dataSwapEnable,
  input wire brd_owner_type         busOwner
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  property p_row;
    busOwner == OWN_REFRESH && addrOe |-> systemAddress[19:8] == '0;
  endproperty
  a_row: assert property (p_row) else $error("refresh high address");
  property p_lowmb;
    busOwner == OWN_REFRESH && !memReadCmdN |-> !lowMbReadStrobeN;
  endproperty
  a_lowmb: assert property (p_lowmb) else $error("low mb strobe");
  // sync lag is two flops, so four low samples must keep the command
  property p_hold;
    (busOwner == OWN_REFRESH && !memReadCmdN && !channelReady)[*4]
      |=> !memReadCmdN;
  endproperty
  a_hold: assert property (p_hold) else $error("refresh read dropped");
  property p_wait;
    busOwner == OWN_DMA |=> busOwner inside {OWN_DMA, OWN_CPU};
  endproperty
  a_wait: assert property (p_wait) else $error("dma preempted");
  property p_pair;
    $fell(memWriteCmdN) || $fell(ioWriteCmdN) |-> !(memReadCmdN && ioReadCmdN);
  endproperty
  a_pair: assert property (p_pair) else $error("write before read");
  property p_setup;
    $rose(dmaAddressEnable) |-> (dmaAcknowledgeN != '1)
      ##36 (memReadCmdN && ioReadCmdN) ##1 !(memReadCmdN && ioReadCmdN);
  endproperty
  a_setup: assert property (p_setup) else $error("dma opening");
  property p_tc;
    $rose(terminalCount) |-> dmaAddressEnable;
  endproperty
  a_tc: assert property (p_tc) else $error("count outside transfer");
  property p_upper;
    dmaAddressEnable && $past(dmaAddressEnable)
      |-> $stable(upperLatchableAddress);
  endproperty
  a_upper: assert property (p_upper) else $error("upper address moved");
  property p_card;
    busOwner == OWN_CARD |-> !cmdOe && !dmaAddressEnable;
  endproperty
  a_card: assert property (p_card) else $error("card owner driven");
  property p_swap;
    dataSwapEnable |-> !(&dmaAcknowledgeN[LAST_NARROW_CH:0]);
  endproperty
  a_swap: assert property (p_swap) else $error("swap on wide");
endmodule : brd_seq_chk

bind brd_bus_sequencer brd_seq_chk u_chk (
  .mclk(mclk), .rst(rst), .channelReady(channelReady),
  .memReadCmdN(memReadCmdN), .memWriteCmdN(memWriteCmdN),
  .ioReadCmdN(ioReadCmdN), .ioWriteCmdN(ioWriteCmdN),
  .lowMbReadStrobeN(lowMbReadStrobeN), .cmdOe(cmdOe), .addrOe(addrOe),
  .systemAddress(systemAddress),
  .upperLatchableAddress(upperLatchableAddress),
  .dmaAcknowledgeN(dmaAcknowledgeN), .dmaAddressEnable(dmaAddressEnable),
  .terminalCount(terminalCount), .dataSwapEnable(dataSwapEnable),
  .busOwner(busOwner)
);

// >>> bench/brd_bus_agent.sv
// far side: dma requesters, a ready-driving resource and a card
// runs on mclk; drives no data lines, so refresh sees none
`timescale 1ns/1ps
module brd_bus_agent
  import brd_pkg::*;
(
  input  wire logic              mclk,
  input  wire logic              rst,
  input  wire logic [NUM_CH-1:0] want,
  input  wire logic [7:0]        slowCyc,
  input  wire logic              cardRef,
  input  wire logic              rdN,
  input  wire logic [NUM_CH-1:0] ackN,
  input  wire brd_owner_type     owner,
  output logic [NUM_CH-1:0]      req,
  output logic                   ready,
  output logic                   refN,
  output logic                   ownN
);
  logic [7:0] cnt_r;
  logic       rdN_r;
  assign ready = cnt_r == 8'h00;
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      req   <= '0;
      cnt_r <= 8'h00;
      rdN_r <= 1'b1;
      refN  <= 1'b1;
      ownN  <= 1'b1;
    end
    else
    begin
      req   <= want | (req & ackN);
      rdN_r <= rdN;
      // a slow resource holds ready low from the read start
      if (rdN_r && !rdN)
        cnt_r <= slowCyc;
      else if (cnt_r != 8'h00)
        cnt_r <= cnt_r - 8'h01;
      // no address or command outputs here, so nothing to float
      refN <= !(cardRef && owner inside {OWN_CARD, OWN_REFRESH});
      ownN <= owner != OWN_CARD;
    end
  end
endmodule : brd_bus_agent

// >>> bench/bus_refresh_dma_ownership_cycles_bench.sv
// self-checking bench for the bus sequencer with its far-side model
// one mclk domain; the refresh interval runs at full length
`timescale 1ns/1ps
module bus_refresh_dma_ownership_cycles_bench;
  import brd_pkg::*;
  localparam int LIM = 20000;
  logic                  mclk, rst, cardRef, memToIo, refreshRequestN;
  logic                  memWideSelectN, ioWideSelectN, zeroWaitRequestN;
  logic [NUM_CH-1:0]     want, cascadeMode, dmaRequestLine, dmaAcknowledgeN;
  logic [7:0]            slowCyc;
  logic [ADDR_W-1:0]     memBase;
  logic [15:0]           xferCount;
  logic                  channelReady, secondaryOwnerN, cmdOe, addrOe;
  logic                  memReadCmdN, memWriteCmdN, ioReadCmdN, ioWriteCmdN;
  logic                  lowMbReadStrobeN, lowMbWriteStrobeN, dataSwapEnable;
  logic [SYS_ADDR_W-1:0] systemAddress;
  logic [UPPER_W-1:0]    upperLatchableAddress;
  logic                  dmaAddressEnable, terminalCount;
  brd_owner_type         busOwner;
  int                    failures, tests_run;

  brd_bus_sequencer dut (
    .mclk(mclk), .rst(rst), .dmaRequestLine(dmaRequestLine),
    .refreshRequestN(refreshRequestN), .channelReady(channelReady),
    .secondaryOwnerN(secondaryOwnerN), .memWideSelectN(memWideSelectN),
    .ioWideSelectN(ioWideSelectN), .zeroWaitRequestN(zeroWaitRequestN),
    .cascadeMode(cascadeMode), .memToIo(memToIo), .memBase(memBase),
    .xferCount(xferCount), .memReadCmdN(memReadCmdN),
    .memWriteCmdN(memWriteCmdN), .ioReadCmdN(ioReadCmdN),
    .ioWriteCmdN(ioWriteCmdN), .lowMbReadStrobeN(lowMbReadStrobeN),
    .lowMbWriteStrobeN(lowMbWriteStrobeN), .cmdOe(cmdOe),
    .systemAddress(systemAddress), .addrOe(addrOe),
    .upperLatchableAddress(upperLatchableAddress),
    .dmaAcknowledgeN(dmaAcknowledgeN), .dmaAddressEnable(dmaAddressEnable),
    .terminalCount(terminalCount), .dataSwapEnable(dataSwapEnable),
    .busOwner(busOwner));
  brd_bus_agent agent (
    .mclk(mclk), .rst(rst), .want(want), .slowCyc(slowCyc),
    .cardRef(cardRef), .rdN(memReadCmdN & ioReadCmdN),
    .ackN(dmaAcknowledgeN), .owner(busOwner), .req(dmaRequestLine),
    .ready(channelReady), .refN(refreshRequestN), .ownN(secondaryOwnerN));

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : report_and_stop

  task automatic check(input string what, input logic [23:0] exp,
                       input logic [23:0] got);
    tests_run++;
    if (got !== exp)
    begin
      failures++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // samples at the falling edge, clear of the registered updates
  task automatic step(inout int n);
    @(negedge mclk);
    n++;
    if (n > LIM)
    begin
      failures++;
      $display("[ERR] wait expected done seen timeout");
      report_and_stop();
    end
  endtask : step

  task automatic ref_cycle(output int gap, output int w,
                           output logic [7:0] row);
    gap = 0;
    while (memReadCmdN !== 1'b0 || busOwner !== OWN_REFRESH)
      step(gap);
    row = systemAddress[7:0];
    check("high row bits", 24'h00_0000, 24'(systemAddress[19:8]));
    check("low mb read", 24'h00_0000, 24'(lowMbReadStrobeN));
    w = 0;
    while (memReadCmdN === 1'b0)
      step(w);
  endtask : ref_cycle

  task automatic dma_xfer(input int ch, output logic [23:0] a,
                          output logic tc, output int w);
    int n;
    n = 0;
    while (dmaAcknowledgeN[ch] !== 1'b0)
      step(n);
    check("address enable", 24'h00_0001, 24'(dmaAddressEnable));
    a = {upperLatchableAddress, systemAddress[UPPER_LSB-1:0]};
    tc = terminalCount;
    n = 0;
    while ((memReadCmdN & ioReadCmdN) === 1'b1)
      step(n);
    check("ack to read", 24'(DMA_ACK_SETUP_CYC), 24'(n));
    n = 0;
    while ((memWriteCmdN & ioWriteCmdN) === 1'b1)
      step(n);
    check("read to write", 24'(DMA_RD_TO_WR_CYC), 24'(n));
    check("swap", 24'(ch <= LAST_NARROW_CH), 24'(dataSwapEnable));
    check("write dir", 24'(memToIo), 24'(memWriteCmdN));
    check("low mb write", 24'(memToIo), 24'(lowMbWriteStrobeN));
    w = 0;
    while ((memWriteCmdN & ioWriteCmdN) === 1'b0)
      step(w);
    n = 0;
    while ((memReadCmdN & ioReadCmdN) === 1'b0)
      step(n);
    check("read hold", 24'(DMA_RD_HOLD_CYC), 24'(n));
    n = 0;
    while (dmaAcknowledgeN[ch] === 1'b0)
      step(n);
    check("ack hold", 24'(DMA_ACK_HOLD_CYC), 24'(n));
  endtask : dma_xfer

  task automatic test_refresh;
    int g, w0, w1;
    logic [7:0] r0, r1;
    @(posedge mclk);
    zeroWaitRequestN <= 1'b0;
    ioWideSelectN    <= 1'b0;
    memWideSelectN   <= 1'b0;
    ref_cycle(g, w0, r0);
    check("refresh width", 24'(REF_CMD_CYC), 24'(w0));
    @(posedge mclk);
    slowCyc <= 8'h78;
    ref_cycle(g, w1, r1);
    check("interval", 24'h00_0001, 24'(w0 + g >= REFRESH_INTERVAL_CYC &&
          w0 + g <= REFRESH_INTERVAL_CYC + 40));
    check("ready held", 24'h00_0001, 24'(w1 > 120));
    check("row step", 24'(r0 + 8'h01), 24'(r1));
    $display("test refresh done");
  endtask : test_refresh

  task automatic test_dma(input int ch, input logic dir, input int step,
                          input logic [7:0] slow);
    logic [23:0] a0, a1;
    logic t0, t1;
    int w;
    @(posedge mclk);
    slowCyc   <= slow;
    memToIo   <= dir;
    memBase   <= 24'h03_FFFF;
    xferCount <= 16'h0001;
    want      <= 8'(1 << ch);
    dma_xfer(ch, a0, t0, w);
    @(posedge mclk);
    want <= 8'h00;
    dma_xfer(ch, a1, t1, w);
    check("first address", 24'h03_FFFF, a0);
    check("next address", 24'(24'h03_FFFF + step), a1);
    check("count early", 24'h00_0000, 24'(t0));
    check("count last", 24'h00_0001, 24'(t1));
    check("write width", 24'(slow == 0 ? DMA_WR_CYC : 1),
          24'(slow == 0 ? w : w > DMA_WR_CYC));
    $display("test dma channel %0d done", ch);
  endtask : test_dma

  task automatic test_cascade;
    int n, w;
    logic [7:0] r0, r1;
    @(posedge mclk);
    slowCyc     <= 8'h00;
    cascadeMode <= 8'h40;
    want        <= 8'h40;
    n = 0;
    while (busOwner !== OWN_CARD)
      step(n);
    check("card ack", 24'h00_0000, 24'(dmaAcknowledgeN[6]));
    @(posedge mclk);
    cardRef <= 1'b1;
    ref_cycle(n, w, r0);
    ref_cycle(n, w, r1);
    check("back to back row", 24'(r0 + 8'h01), 24'(r1));
    @(posedge mclk);
    cardRef <= 1'b0;
    n = 0;
    while (busOwner !== OWN_CARD)
      step(n);
    @(posedge mclk);
    want <= 8'h00;
    n = 0;
    while (busOwner !== OWN_CPU)
      step(n);
    check("card ack off", 24'h00_0001, 24'(dmaAcknowledgeN[6]));
    $display("test cascade done");
  endtask : test_cascade

  initial
  begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  initial
  begin
    failures = 0;
    tests_run = 0;
    rst = 1'b1;
    cardRef = 1'b0;
    memToIo = 1'b1;
    memWideSelectN = 1'b1;
    ioWideSelectN = 1'b1;
    zeroWaitRequestN = 1'b1;
    want = 8'h00;
    cascadeMode = 8'h00;
    slowCyc = 8'h00;
    memBase = 24'h00_0000;
    xferCount = 16'h0000;
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    test_refresh();
    test_dma(1, 1'b1, 1, 8'h00);
    test_dma(5, 1'b0, 2, 8'hFA);
    test_cascade();
    report_and_stop();
  end
endmodule : bus_refresh_dma_ownership_cycles_bench
